// ===== design/bcb_cond_eval.sv
`default_nettype none
module bcb_cond_eval
  import bcb_pkg::*;
(
  // Inputs
  input  wire logic [3:0] cc,
  input  wire bcb_flags_t flags,
  // Result
  output logic            taken
);

  always_comb
  begin
    unique case (cc)
      CC_ALWAYS_TAKEN:   taken = 1'b1;
      CC_NEVER_TAKEN:    taken = 1'b0;
      CC_HIGHER:         taken = ~(flags.c | flags.z);
      CC_LOWER_SAME:     taken = flags.c | flags.z;
      CC_CARRY_CLEAR:    taken = ~flags.c;
      CC_CARRY_SET:      taken = flags.c;
      CC_NOT_EQUAL:      taken = ~flags.z;
      CC_EQUAL:          taken = flags.z;
      CC_OVERFLOW_CLEAR: taken = ~flags.v;
      CC_OVERFLOW_SET:   taken = flags.v;
      CC_PLUS:           taken = ~flags.n;
      CC_MINUS:          taken = flags.n;
      CC_GREATER_EQUAL:  taken = ~(flags.n ^ flags.v);
      CC_LESS_THAN:      taken = flags.n ^ flags.v;
      CC_GREATER_THAN:   taken = ~(flags.z | (flags.n ^ flags.v));
      CC_LESS_EQUAL:     taken = flags.z | (flags.n ^ flags.v);
    endcase
  end

endmodule
`default_nettype wire

// ===== design/bcb_unit.sv
// What this block does
// - Bit OR into carry: C becomes C or selected bit.
// - Inverted bit OR: C becomes C or not selected bit.
// - Bit XOR into carry: C becomes C xor selected bit.
// - Inverted bit XOR: C becomes C xor not selected bit.
// - Bit load: C becomes selected bit.
// - Inverted bit load: C becomes not selected bit.
// - Carry to bit: selected bit becomes C, other bits kept.
// - Inverted carry to bit: selected bit becomes not C.
// - All forms take bit number from 3-bit immediate only.
// - Conditional branch loads target only when condition true.
// - Unsigned conditions from C or Z, and C alone.
// - Single-flag conditions on Z, V and N.
// - Signed conditions from N xor V, and Z.
// - Absolute jump loads target without looking at flags.
// - Calls branch keeping a return point unless the stack is full; return resumes there.
//
// Design decisions made here: the APB interface to the registers and the address map.
`default_nettype none
module bcb_unit
  import bcb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
)
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // Stack index wraps modulo depth, so only powers of two serve
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
  begin : g_bad_depth
    $error("STACK_DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [12:0]       ctrl_r;
  logic [7:0]        operand_r;
  logic [ADDR_W-1:0] target_r;
  bcb_flags_t        flags_r;
  logic [ADDR_W-1:0] pc_r;
  logic [SP_W:0]     sp_r;
  logic [7:0]        result_r;
  logic              busy_r;
  logic              taken_r;
  logic              fault_r;
  logic [ADDR_W-1:0] stack_mem [STACK_DEPTH];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic addr_ok;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  always_comb
  begin
    unique case (paddr)
      OFS_CTRL, OFS_OPERAND, OFS_TARGET, OFS_CCR, OFS_PC, OFS_SP,
      OFS_RESULT, OFS_STATUS, OFS_STACK: addr_ok = 1'b1;
      default:                           addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  bcb_op_t           op;
  logic [2:0]        bit_no;
  logic              sel_bit;
  logic              cond_taken;
  logic [ADDR_W-1:0] next_pc;
  logic              push_ok;
  logic              pop_ok;
  logic              go;

  assign op      = bcb_op_t'(ctrl_r[CTRL_OP_LSB +: 5]);
  // Bit number is the 3-bit immediate in every form
  assign bit_no  = ctrl_r[CTRL_BIT_LSB +: 3];
  assign sel_bit = operand_r[bit_no];
  assign next_pc = pc_r + INSN_LEN;
  assign push_ok = sp_r < (SP_W+1)'(STACK_DEPTH);
  assign pop_ok  = sp_r != '0;
  assign go      = busy_r;

  bcb_cond_eval u_cond
  (
    .cc    (ctrl_r[CTRL_CC_LSB +: 4]),
    .flags (flags_r),
    .taken (cond_taken)
  );

  // ----------------------------------------------------------------
  // Flag and status words as software sees them
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ccr_word;
  logic [DATA_W-1:0] status_word;
  bcb_flags_t        ccr_wr;

  // Field positions kept apart from the struct order on purpose
  always_comb
  begin
    ccr_word                    = '0;
    ccr_word[CCR_C_POS]         = flags_r.c;
    ccr_word[CCR_V_POS]         = flags_r.v;
    ccr_word[CCR_Z_POS]         = flags_r.z;
    ccr_word[CCR_N_POS]         = flags_r.n;
    status_word                 = '0;
    status_word[STAT_BUSY_POS]  = busy_r;
    status_word[STAT_TAKEN_POS] = taken_r;
    status_word[STAT_FAULT_POS] = fault_r;
    ccr_wr.c                    = pwdata[CCR_C_POS];
    ccr_wr.v                    = pwdata[CCR_V_POS];
    ccr_wr.z                    = pwdata[CCR_Z_POS];
    ccr_wr.n                    = pwdata[CCR_N_POS];
  end

  // ----------------------------------------------------------------
  // Carry and other flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      flags_r <= bcb_flags_t'(CCR_RST);
    else if (go)
    begin
      // Only C ever moves here; N, Z, V held for every op
      unique case (op)
        OP_BIT_OR_CARRY:            flags_r.c <= flags_r.c | sel_bit;
        OP_INVERTED_BIT_OR_CARRY:   flags_r.c <= flags_r.c | ~sel_bit;
        OP_BIT_XOR_CARRY:           flags_r.c <= flags_r.c ^ sel_bit;
        OP_INVERTED_BIT_XOR_CARRY:  flags_r.c <= flags_r.c ^ ~sel_bit;
        OP_BIT_LOAD_CARRY:          flags_r.c <= sel_bit;
        OP_INVERTED_BIT_LOAD_CARRY: flags_r.c <= ~sel_bit;
        default:                    flags_r <= flags_r;
      endcase
    end
    else if (wr_en && paddr == OFS_CCR)
      flags_r <= ccr_wr;
  end

  // ----------------------------------------------------------------
  // Byte result of the store forms
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      result_r <= 8'h00;
    else if (go && op == OP_CARRY_TO_BIT)
    begin
      result_r         <= operand_r;
      result_r[bit_no] <= flags_r.c;
    end
    else if (go && op == OP_INVERTED_CARRY_TO_BIT)
    begin
      result_r         <= operand_r;
      result_r[bit_no] <= ~flags_r.c;
    end
  end

  // ----------------------------------------------------------------
  // Program counter, stack pointer, taken flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pc_r    <= PC_RST;
      sp_r    <= SP_RST[SP_W:0];
      taken_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else if (go)
    begin
      taken_r <= 1'b0;
      pc_r    <= next_pc;
      unique case (op)
        OP_COND_BRANCH:
        begin
          if (cond_taken)
          begin
            pc_r    <= target_r;
            taken_r <= 1'b1;
          end
        end
        OP_JUMP_ABSOLUTE:
        begin
          pc_r    <= target_r;
          taken_r <= 1'b1;
        end
        OP_RELATIVE_SUBROUTINE_CALL, OP_JUMP_TO_SUBROUTINE:
        begin
          // Overflow would lose the return point, so refuse the call
          if (push_ok)
          begin
            pc_r    <= target_r;
            sp_r    <= sp_r + 1'b1;
            taken_r <= 1'b1;
          end
          else
            fault_r <= 1'b1;
        end
        OP_RETURN_SUBROUTINE:
        begin
          if (pop_ok)
          begin
            pc_r    <= stack_mem[sp_r[SP_W-1:0] - 1'b1];
            sp_r    <= sp_r - 1'b1;
            taken_r <= 1'b1;
          end
          else
            fault_r <= 1'b1;
        end
        default: ;
      endcase
    end
    else if (wr_en && paddr == OFS_PC)
      pc_r <= pwdata[ADDR_W-1:0];
    else if (wr_en && paddr == OFS_SP)
      sp_r <= pwdata[SP_W:0] > (SP_W+1)'(STACK_DEPTH) ? sp_r : pwdata[SP_W:0];
    else if (wr_en && paddr == OFS_STATUS && pwdata[STAT_FAULT_POS])
      fault_r <= 1'b0;
  end

  // Return stack contents; no reset needed, guarded by sp_r
  always_ff @(posedge ref_clk)
  begin
    if (!srst && go && push_ok &&
        (op == OP_RELATIVE_SUBROUTINE_CALL || op == OP_JUMP_TO_SUBROUTINE))
      stack_mem[sp_r[SP_W-1:0]] <= next_pc;
  end

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_r    <= '0;
      operand_r <= 8'h00;
      target_r  <= PC_RST;
      busy_r    <= 1'b0;
    end
    else
    begin
      busy_r <= 1'b0;
      if (wr_en && paddr == OFS_CTRL)
      begin
        ctrl_r <= pwdata[12:0];
        busy_r <= pwdata[CTRL_GO_POS];
      end
      if (wr_en && paddr == OFS_OPERAND)
        operand_r <= pwdata[7:0];
      if (wr_en && paddr == OFS_TARGET)
        target_r <= pwdata[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // APB answer: no wait states, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup && !pwrite)
      begin
        unique case (paddr)
          OFS_CTRL:    prdata <= DATA_W'(ctrl_r);
          OFS_OPERAND: prdata <= DATA_W'(operand_r);
          OFS_TARGET:  prdata <= DATA_W'(target_r);
          OFS_CCR:     prdata <= ccr_word;
          OFS_PC:      prdata <= DATA_W'(pc_r);
          OFS_SP:      prdata <= DATA_W'(sp_r);
          OFS_RESULT:  prdata <= DATA_W'(result_r);
          OFS_STATUS:  prdata <= status_word;
          OFS_STACK:   prdata <= pop_ok ? DATA_W'(stack_mem[sp_r[SP_W-1:0] - 1'b1]) : '0;
          default:     prdata <= '0;
        endcase
      end
      else
        prdata <= '0;
    end
  end

endmodule
`default_nettype wire

// ===== include/bcb_pkg.sv
`default_nettype none
package bcb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_TARGET  = 8'h08;
  localparam logic [7:0] OFS_CCR     = 8'h0C;
  localparam logic [7:0] OFS_PC      = 8'h10;
  localparam logic [7:0] OFS_SP      = 8'h14;
  localparam logic [7:0] OFS_RESULT  = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_STACK   = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // CTRL: [4:0] op, [7:5] bit number, [11:8] condition, [12] go
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_BIT_LSB = 5;
  localparam int CTRL_CC_LSB  = 8;
  localparam int CTRL_GO_POS  = 12;
  // CCR: [0] C, [1] V, [2] Z, [3] N
  localparam int CCR_C_POS = 0;
  localparam int CCR_V_POS = 1;
  localparam int CCR_Z_POS = 2;
  localparam int CCR_N_POS = 3;
  // STATUS: [0] busy, [1] taken, [2] stack fault
  localparam int STAT_BUSY_POS  = 0;
  localparam int STAT_TAKEN_POS = 1;
  localparam int STAT_FAULT_POS = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PC_RST  = 24'h00_0000;
  localparam logic [ADDR_W-1:0] SP_RST  = 24'h00_0000;
  localparam logic [3:0]        CCR_RST = 4'h0;
  localparam logic [ADDR_W-1:0] INSN_LEN = 24'h00_0002;

  // ----------------------------------------------------------------
  // Operations and conditions
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE                   = 5'h00,
    OP_BIT_OR_CARRY           = 5'h01,
    OP_INVERTED_BIT_OR_CARRY  = 5'h02,
    OP_BIT_XOR_CARRY          = 5'h03,
    OP_INVERTED_BIT_XOR_CARRY = 5'h04,
    OP_BIT_LOAD_CARRY         = 5'h05,
    OP_INVERTED_BIT_LOAD_CARRY = 5'h06,
    OP_CARRY_TO_BIT           = 5'h07,
    OP_INVERTED_CARRY_TO_BIT  = 5'h08,
    OP_COND_BRANCH            = 5'h09,
    OP_JUMP_ABSOLUTE          = 5'h0A,
    OP_RELATIVE_SUBROUTINE_CALL = 5'h0B,
    OP_JUMP_TO_SUBROUTINE     = 5'h0C,
    OP_RETURN_SUBROUTINE      = 5'h0D
  } bcb_op_t;

  typedef enum logic [3:0] {
    CC_ALWAYS_TAKEN   = 4'h0,
    CC_NEVER_TAKEN    = 4'h1,
    CC_HIGHER         = 4'h2,
    CC_LOWER_SAME     = 4'h3,
    CC_CARRY_CLEAR    = 4'h4,
    CC_CARRY_SET      = 4'h5,
    CC_NOT_EQUAL      = 4'h6,
    CC_EQUAL          = 4'h7,
    CC_OVERFLOW_CLEAR = 4'h8,
    CC_OVERFLOW_SET   = 4'h9,
    CC_PLUS           = 4'hA,
    CC_MINUS          = 4'hB,
    CC_GREATER_EQUAL  = 4'hC,
    CC_LESS_THAN      = 4'hD,
    CC_GREATER_THAN   = 4'hE,
    CC_LESS_EQUAL     = 4'hF
  } bcb_cc_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bcb_flags_t;

endpackage
`default_nettype wire

// ===== tb/bcb_unit_asserts.sv
`default_nettype none
module bcb_unit_asserts
  import bcb_pkg::*;
#(
  parameter int STACK_DEPTH = 16
)
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              srst,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_cause; pready |-> $past(psel && !penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_rst_quiet; $fell(srst) |-> !pready && prdata == '0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("bus not quiet after reset");

  // ----------------------------------------------------------------
  // Decode and read data
  // ----------------------------------------------------------------
  property p_err_unmapped; pready && paddr > OFS_STACK |-> pslverr && prdata == '0; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_no_err; pready && paddr <= OFS_STACK && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("mapped access refused");
  property p_idle_zero; !pready |-> prdata == '0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
  property p_ccr_width; pready && !pwrite && paddr == OFS_CCR |-> prdata[31:4] == '0;
  endproperty
  a_ccr_width: assert property (p_ccr_width) else $error("flag word too wide");
  property p_result_width; pready && !pwrite && paddr == OFS_RESULT |-> prdata[31:8] == '0;
  endproperty
  a_result_width: assert property (p_result_width) else $error("result too wide");
  property p_sp_bound; pready && !pwrite && paddr == OFS_SP |-> prdata <= STACK_DEPTH;
  endproperty
  a_sp_bound: assert property (p_sp_bound) else $error("stack pointer past depth");
endmodule

bind bcb_unit bcb_unit_asserts #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import bcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic              ref_clk = 1'b0;
  logic              srst    = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [7:0]        paddr   = 8'h00;
  logic [DATA_W-1:0] pwdata  = '0;
  wire  [DATA_W-1:0] prdata;
  wire               pready;
  wire               pslverr;
  logic [31:0]       rd;
  logic              err;
  int                error_cnt    = 0;
  int                total_checks = 0;

  bcb_unit #(.STACK_DEPTH(DEPTH)) u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Idle cycle after each transfer keeps psel from being driven twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  task automatic exec(input logic [4:0] op, input logic [2:0] k, input logic [3:0] cc);
    apb(1'b1, OFS_CTRL, {19'h0_0000, 1'b1, cc, k, op});
  endtask

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic cexp(input logic [4:0] op, input logic c, input logic b);
    case (op)
      5'h01: return c | b;
      5'h02: return c | ~b;
      5'h03: return c ^ b;
      5'h04: return c ^ ~b;
      5'h05: return b;
      5'h06: return ~b;
      default: return c;
    endcase
  endfunction
  // Flags packed n, z, v, c; odd codes are the inverse of the even ones
  function automatic logic taken(input logic [3:0] cc, input logic [3:0] f);
    logic t;
    case (cc[3:1])
      3'd0: t = 1'b1;
      3'd1: t = ~(f[0] | f[2]);
      3'd2: t = ~f[0];
      3'd3: t = ~f[2];
      3'd4: t = ~f[1];
      3'd5: t = ~f[3];
      3'd6: t = ~(f[3] ^ f[1]);
      default: t = ~(f[2] | (f[3] ^ f[1]));
    endcase
    return t ^ cc[0];
  endfunction

  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100_000;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0]  b;
    logic [7:0]  res;
    logic [2:0]  k;
    logic [3:0]  f;
    logic [4:0]  op;
    logic [23:0] pc;
    logic [23:0] tg;
    logic [23:0] q[$];
    void'($urandom(32'h816d_f766));
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk_rd(OFS_CCR, 32'h0000_0000);
    chk_rd(OFS_PC, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    `CHK(err, 1'b1)
    // Every bit op, all-zero and all-ones bytes first
    for (int i = 0; i < 160; i++)
    begin
      op = 5'(i % 8 + 1); b = 8'($urandom); k = 3'($urandom); f = 4'($urandom);
      if (i < 16) b = i[3] ? 8'hFF : 8'h00;
      apb(1'b1, OFS_OPERAND, {24'h00_0000, b});
      apb(1'b1, OFS_CCR, {28'h000_0000, f});
      exec(op, k, 4'($urandom));
      chk_rd(OFS_CCR, {28'h0, f[3:1], cexp(op, f[0], b[k])});
      res = b;
      res[k] = f[0] ^ (op == 5'h08);
      if (op > 5'h06) chk_rd(OFS_RESULT, {24'h00_0000, res});
    end
    // Every condition against random flags
    for (int i = 0; i < 96; i++)
    begin
      f = 4'($urandom); pc = 24'($urandom) & 24'hFF_FFFE; tg = 24'($urandom) & 24'hFF_FFFE;
      apb(1'b1, OFS_CCR, {28'h000_0000, f});
      apb(1'b1, OFS_PC, {8'h00, pc});
      apb(1'b1, OFS_TARGET, {8'h00, tg});
      exec((i % 6 == 5) ? 5'h0A : 5'h09, 3'($urandom), 4'(i));
      chk_rd(OFS_PC, {8'h00, (i % 6 == 5 || taken(4'(i), f)) ? tg : pc + 24'd2});
      chk_rd(OFS_CCR, {28'h000_0000, f});
    end
    // Nested calls to full stack, one too many, then returns past empty
    apb(1'b1, OFS_SP, 32'h0000_0000);
    pc = 24'h00_0100;
    apb(1'b1, OFS_PC, {8'h00, pc});
    for (int i = 0; i < DEPTH; i++)
    begin
      tg = 24'h00_1000 + 24'(i * 16);
      apb(1'b1, OFS_TARGET, {8'h00, tg});
      exec(5'(i % 2 + 11), 3'h0, 4'h0);
      q.push_back(pc + 24'd2);
      chk_rd(OFS_STACK, {8'h00, pc + 24'd2});
      chk_rd(OFS_PC, {8'h00, tg});
      pc = tg;
    end
    chk_rd(OFS_SP, 32'(DEPTH));
    exec(5'h0B, 3'h0, 4'h0);
    chk_rd(OFS_PC, {8'h00, pc + 24'd2});
    chk_rd(OFS_SP, 32'(DEPTH));
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK(rd[STAT_FAULT_POS], 1'b1)
    apb(1'b1, OFS_STATUS, 32'(1 << STAT_FAULT_POS));
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK(rd[STAT_FAULT_POS], 1'b0)
    for (int i = 0; i < DEPTH; i++)
    begin
      exec(5'h0D, 3'h0, 4'h0);
      chk_rd(OFS_PC, {8'h00, q.pop_back()});
    end
    exec(5'h0D, 3'h0, 4'h0);
    chk_rd(OFS_PC, {8'h00, 24'h00_0100 + 24'd4});
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK(rd[STAT_FAULT_POS], 1'b1)
    summarize();
  end
endmodule
`default_nettype wire
